// File: design/radio_rx_pkg.sv
// shared constants, types and helpers for the receive control block and its host
package radio_rx_pkg;

    // device register port
    localparam logic [7:0] RX_CTRL_ADDR  = 8'h05;
    localparam logic [7:0] RX_CTRL_RESET = 8'h07;
    localparam logic [7:0] RD_ZERO       = 8'h00;

    // receive_control field positions
    localparam int GO_BIT       = 7;
    localparam int RSVD_BIT     = 6;
    localparam int FULL_BIT     = 5;
    localparam int HALF_BIT     = 4;
    localparam int NONEMPTY_BIT = 3;
    localparam int BUFFAULT_BIT = 2;
    localparam int COMPLETE_BIT = 1;
    localparam int FAULT_BIT    = 0;
    localparam int EN_W         = 6;

    // receive buffer levels
    localparam logic [4:0] RX_DEPTH      = 5'h10;
    localparam logic [4:0] RX_HALF_LEVEL = 5'h08;
    localparam logic [4:0] RX_ONE_LEVEL  = 5'h01;

    // host APB map
    localparam logic [11:0] CMD_OFF   = 12'h000;
    localparam logic [11:0] STAT_OFF  = 12'h004;
    localparam logic [11:0] ISTAT_OFF = 12'h008;
    localparam logic [11:0] IMASK_OFF = 12'h00C;

    // host command and status word fields
    localparam int CMD_ADDR_LSB  = 0;
    localparam int CMD_WDATA_LSB = 8;
    localparam int CMD_WE_BIT    = 16;
    localparam int CMD_START_BIT = 31;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_RD_LSB   = 8;

    // host interrupt bits
    localparam int HIRQ_DONE = 0;
    localparam int HIRQ_DEV  = 1;
    localparam int HIRQ_W    = 2;

    localparam logic [31:0] APB_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        D_IDLE = 3'b001,
        D_WARM = 3'b010,
        D_RECV = 3'b100
    } dev_state_t;

    typedef enum logic [1:0] {
        H_IDLE = 2'b01,
        H_BUSY = 2'b10
    } host_state_t;

    // sticky update: a set in the same cycle as a clear wins
    function automatic logic sticky_upd(input logic cur, input logic set, input logic clr);
        sticky_upd = (cur & ~clr) | set;
    endfunction : sticky_upd

endpackage : radio_rx_pkg

// File: design/radio_reg_if.sv
// register port between the host controller and the radio receive control
`timescale 1ns/1ps
interface radio_reg_if;
    logic       req;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       ack;
    logic       irq;

    modport host (output req, output we, output addr, output wdata, input rdata, input ack, input irq);
    modport dev  (input req, input we, input addr, input wdata, output rdata, output ack, output irq);
endinterface : radio_reg_if

// File: design/rx_irq_flags.sv
// receive status flags and the gated interrupt output
`timescale 1ns/1ps
module rx_irq_flags (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic [4:0]                    rx_level,
    input  wire logic                          rx_data_in,
    input  wire logic                          rx_buffer_read,
    input  wire logic                          sop_in,
    input  wire logic                          rx_complete_in,
    input  wire logic                          rx_error_in,
    input  wire logic                          status_clear,
    input  wire logic                          go,
    input  wire logic [radio_rx_pkg::EN_W-1:0] enables,
    output logic      [radio_rx_pkg::EN_W-1:0] status,
    output logic                               irq
);
    logic buf_fault_r;
    logic complete_r;
    logic fault_r;
    logic [radio_rx_pkg::EN_W-1:0] status_nxt;

    // read of an empty buffer or data into a full one; cleared by a packet start while receive is armed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_fault_r <= 1'b0;
        end else begin
            buf_fault_r <= radio_rx_pkg::sticky_upd(buf_fault_r,
                (rx_buffer_read && rx_level == '0) || (rx_data_in && rx_level == radio_rx_pkg::RX_DEPTH),
                go && sop_in);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            complete_r <= 1'b0;
            fault_r    <= 1'b0;
        end else begin
            complete_r <= radio_rx_pkg::sticky_upd(complete_r, rx_complete_in, status_clear);
            fault_r    <= radio_rx_pkg::sticky_upd(fault_r, rx_error_in, status_clear);
        end
    end

    // level flags follow the buffer fill regardless of the enables
    always_comb begin
        status_nxt = '0;
        status_nxt[radio_rx_pkg::FULL_BIT]     = (rx_level == radio_rx_pkg::RX_DEPTH);
        status_nxt[radio_rx_pkg::HALF_BIT]     = (rx_level >= radio_rx_pkg::RX_HALF_LEVEL);
        status_nxt[radio_rx_pkg::NONEMPTY_BIT] = (rx_level >= radio_rx_pkg::RX_ONE_LEVEL);
        status_nxt[radio_rx_pkg::BUFFAULT_BIT] = buf_fault_r;
        status_nxt[radio_rx_pkg::COMPLETE_BIT] = complete_r;
        status_nxt[radio_rx_pkg::FAULT_BIT]    = fault_r;
    end

    // registered so the pin never glitches; costs one cycle of latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
            irq    <= 1'b0;
        end else begin
            status <= status_nxt;
            irq    <= |(status_nxt & enables);
        end
    end
endmodule : rx_irq_flags

// File: design/radio_rx_ctrl.sv
// device end: receive control register, receive start sequencing and interrupt gating
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module radio_rx_ctrl (
    input  wire logic       pclk,
    input  wire logic       presetn,
    radio_reg_if.dev        bus,
    input  wire logic [4:0] rx_level,
    input  wire logic       rx_data_in,
    input  wire logic       rx_buffer_read,
    input  wire logic       sop_in,
    input  wire logic       rx_complete_in,
    input  wire logic       rx_error_in,
    input  wire logic       rx_done,
    input  wire logic       status_clear,
    input  wire logic       osc_ready,
    input  wire logic       synth_ready,
    output logic            rx_mode,
    output logic            osc_enable,
    output logic            synth_enable,
    output logic [5:0]      rx_status
);
    logic                   ack_r;
    logic [7:0]             rdata_r;
    logic                   go_r;
    logic                   rsvd_r;
    logic [5:0]             en_r;
    logic                   take;
    logic                   ctrl_hit;
    logic                   go_set;
    logic                   ctrl_wr;
    logic                   ctrl_rd;
    logic                   warm_done;
    logic                   clk_req_nxt;
    logic                   rx_mode_nxt;
    radio_rx_pkg::dev_state_t state_r;
    radio_rx_pkg::dev_state_t state_nxt;
    logic                   irq_w;

    // the register decode is shared by the write path, the read path and the start bit
    function automatic logic is_ctrl(input logic [7:0] a);
        is_ctrl = (a == radio_rx_pkg::RX_CTRL_ADDR);
    endfunction : is_ctrl

    // readback order: start, reserved, then the six enables
    function automatic logic [7:0] ctrl_word(input logic go, input logic rsvd, input logic [5:0] en);
        ctrl_word = {go, rsvd, en};
    endfunction : ctrl_word

    // both clock requests follow one decode of the next state
    function automatic logic wants_clocks(input radio_rx_pkg::dev_state_t s);
        wants_clocks = (s != radio_rx_pkg::D_IDLE);
    endfunction : wants_clocks

    function automatic logic is_receiving(input radio_rx_pkg::dev_state_t s);
        is_receiving = (s == radio_rx_pkg::D_RECV);
    endfunction : is_receiving

    // one access per request: ack is a single cycle, the host drops req after it
    assign take     = bus.req && !ack_r;
    assign ctrl_hit = is_ctrl(bus.addr);
    assign ctrl_wr  = take && bus.we && ctrl_hit;
    assign ctrl_rd  = take && !bus.we;
    assign go_set   = ctrl_wr && bus.wdata[radio_rx_pkg::GO_BIT];

    // ack blocks a second take of the same request, so each access lands once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= take;
        end
    end

    // read data is captured once per read and then held, so the host may take it late
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= radio_rx_pkg::RD_ZERO;
        end else if (ctrl_rd) begin
            rdata_r <= ctrl_hit ? ctrl_word(go_r, rsvd_r, en_r) : radio_rx_pkg::RD_ZERO;
        end
    end

    // start bit: only a one sets it, a zero write is ignored; end of receive clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_r <= radio_rx_pkg::RX_CTRL_RESET[radio_rx_pkg::GO_BIT];
        end else if (go_set) begin
            go_r <= 1'b1;
        end else if (rx_done) begin
            go_r <= 1'b0;
        end
    end

    // enables are plain storage; the pairing of bits 3 and 4 is left to software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= radio_rx_pkg::RX_CTRL_RESET[radio_rx_pkg::EN_W-1:0];
        end else if (ctrl_wr) begin
            en_r <= bus.wdata[radio_rx_pkg::EN_W-1:0];
        end
    end

    // reserved bit is stored as written so a stray one shows up on readback
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsvd_r <= radio_rx_pkg::RX_CTRL_RESET[radio_rx_pkg::RSVD_BIT];
        end else if (ctrl_wr) begin
            rsvd_r <= bus.wdata[radio_rx_pkg::RSVD_BIT];
        end
    end

    // clocks already running report ready at once, so warm-up then costs one cycle
    assign warm_done = osc_ready && synth_ready;

    // receive sequencing: wait for oscillator and synthesizer, then receive
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            radio_rx_pkg::D_IDLE: begin
                if (go_r) begin
                    state_nxt = radio_rx_pkg::D_WARM;
                end
            end
            radio_rx_pkg::D_WARM: begin
                if (!go_r) begin
                    state_nxt = radio_rx_pkg::D_IDLE;
                end else if (warm_done) begin
                    state_nxt = radio_rx_pkg::D_RECV;
                end
            end
            radio_rx_pkg::D_RECV: begin
                if (!go_r) begin
                    state_nxt = radio_rx_pkg::D_IDLE;
                end
            end
            default: begin
                state_nxt = radio_rx_pkg::D_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= radio_rx_pkg::D_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign clk_req_nxt = wants_clocks(state_nxt);
    assign rx_mode_nxt = is_receiving(state_nxt);

    // clocks stay requested for the whole receive so they do not drop mid packet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_enable   <= 1'b0;
            synth_enable <= 1'b0;
        end else begin
            osc_enable   <= clk_req_nxt;
            synth_enable <= clk_req_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_mode <= 1'b0;
        end else begin
            rx_mode <= rx_mode_nxt;
        end
    end

    // the start bit also feeds the flags, since a packet start while armed clears a buffer fault
    rx_irq_flags u_flags (
        .pclk           (pclk),
        .presetn        (presetn),
        .rx_level       (rx_level),
        .rx_data_in     (rx_data_in),
        .rx_buffer_read (rx_buffer_read),
        .sop_in         (sop_in),
        .rx_complete_in (rx_complete_in),
        .rx_error_in    (rx_error_in),
        .status_clear   (status_clear),
        .go             (go_r),
        .enables        (en_r),
        .status         (rx_status),
        .irq            (irq_w)
    );

    // the port is driven from registers only; nothing here is combinational toward the host
    assign bus.ack   = ack_r;
    assign bus.rdata = rdata_r;
    assign bus.irq   = irq_w;
endmodule : radio_rx_ctrl

// File: design/radio_rx_host.sv
// host end: APB command registers that drive the radio register port
`timescale 1ns/1ps
module radio_rx_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    radio_reg_if.host        bus,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);
    logic                     wr;
    logic                     rd;
    logic                     start;
    logic                     req_r;
    logic                     we_r;
    logic [7:0]               addr_r;
    logic [7:0]               wdata_r;
    logic [7:0]               rd_r;
    logic                     dev_irq_q;
    logic [1:0]               ist_r;
    logic [1:0]               imask_r;
    logic [1:0]               ev;
    radio_rx_pkg::host_state_t state_r;

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr      = psel && penable && pwrite;
    assign rd      = psel && !pwrite;
    // a start while busy is dropped, so one request is in flight at a time
    assign start   = wr && paddr == radio_rx_pkg::CMD_OFF && pwdata[radio_rx_pkg::CMD_START_BIT]
                     && state_r == radio_rx_pkg::H_IDLE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= radio_rx_pkg::H_IDLE;
            req_r   <= 1'b0;
            we_r    <= 1'b0;
            addr_r  <= 8'h00;
            wdata_r <= 8'h00;
            rd_r    <= 8'h00;
        end else begin
            unique case (state_r)
                radio_rx_pkg::H_IDLE: begin
                    if (start) begin
                        state_r <= radio_rx_pkg::H_BUSY;
                        req_r   <= 1'b1;
                        we_r    <= pwdata[radio_rx_pkg::CMD_WE_BIT];
                        addr_r  <= pwdata[radio_rx_pkg::CMD_ADDR_LSB +: 8];
                        wdata_r <= pwdata[radio_rx_pkg::CMD_WDATA_LSB +: 8];
                    end
                end
                radio_rx_pkg::H_BUSY: begin
                    if (bus.ack) begin
                        state_r <= radio_rx_pkg::H_IDLE;
                        req_r   <= 1'b0;
                        rd_r    <= bus.rdata;
                    end
                end
                default: begin
                    state_r <= radio_rx_pkg::H_IDLE;
                end
            endcase
        end
    end

    assign ev[radio_rx_pkg::HIRQ_DONE] = (state_r == radio_rx_pkg::H_BUSY) && bus.ack;
    assign ev[radio_rx_pkg::HIRQ_DEV]  = bus.irq && !dev_irq_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dev_irq_q <= 1'b0;
            ist_r     <= 2'b00;
            imask_r   <= 2'b00;
            irq       <= 1'b0;
        end else begin
            dev_irq_q <= bus.irq;
            for (int i = 0; i < radio_rx_pkg::HIRQ_W; i++) begin
                ist_r[i] <= radio_rx_pkg::sticky_upd(ist_r[i], ev[i],
                    wr && paddr == radio_rx_pkg::ISTAT_OFF && pwdata[i]);
            end
            if (wr && paddr == radio_rx_pkg::IMASK_OFF) begin
                imask_r <= pwdata[radio_rx_pkg::HIRQ_W-1:0];
            end
            irq <= |(ist_r & imask_r);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= radio_rx_pkg::APB_ZERO;
        end else if (rd && !penable) begin
            prdata <= radio_rx_pkg::APB_ZERO;
            unique case (paddr)
                radio_rx_pkg::STAT_OFF: begin
                    prdata[radio_rx_pkg::STAT_BUSY_BIT]    <= (state_r == radio_rx_pkg::H_BUSY);
                    prdata[radio_rx_pkg::STAT_RD_LSB +: 8] <= rd_r;
                end
                radio_rx_pkg::ISTAT_OFF: prdata[radio_rx_pkg::HIRQ_W-1:0] <= ist_r;
                radio_rx_pkg::IMASK_OFF: prdata[radio_rx_pkg::HIRQ_W-1:0] <= imask_r;
                default: prdata <= radio_rx_pkg::APB_ZERO;
            endcase
        end
    end

    assign bus.req   = req_r;
    assign bus.we    = we_r;
    assign bus.addr  = addr_r;
    assign bus.wdata = wdata_r;
endmodule : radio_rx_host

// File: verification/radio_reg_monitor.sv
// checker for the register port between host end and device end
`timescale 1ns/1ps
module radio_reg_monitor (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       req,
    input wire logic       we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       ack,
    input wire logic       irq
);
    logic [6:0] shadow_r;
    logic       take;
    logic       hit;

    assign take = req && !ack;
    assign hit  = addr == radio_rx_pkg::RX_CTRL_ADDR;

    // enables and reserved bit only change by writes, so a shadow copy is exact
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow_r <= radio_rx_pkg::RX_CTRL_RESET[6:0];
        end else if (take && we && hit) begin
            shadow_r <= wdata[6:0];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ack_next_cycle: assert property (take |=> ack) else $error("ack missing");
    a_ack_one_pulse: assert property (ack |=> !ack) else $error("ack too long");
    a_req_released: assert property (ack |=> !req) else $error("req not dropped");
    a_req_held: assert property (take |=> $stable(addr) && $stable(we) && $stable(wdata))
        else $error("request changed");
    a_unmapped_zero: assert property (take && !we && !hit |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_enable_readback: assert property (take && !we && hit |=> rdata[6:0] == shadow_r)
        else $error("enable bits differ");
    a_rdata_holds: assert property (!(take && !we) |=> $stable(rdata))
        else $error("rdata changed");
    a_irq_needs_enable: assert property ((shadow_r[5:0] == 6'h00) [*3] |-> !irq)
        else $error("irq with all enables off");

    cover property (take && we && hit && wdata[7]);
    cover property (take && !we && hit);
    cover property ($rose(irq));
endmodule : radio_reg_monitor

// File: verification/radio_receive_control_test.sv
// testbench joining host end and device end, driven over APB
`timescale 1ns/1ps
module radio_receive_control_test;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        hirq;
    logic [4:0]  rx_level;
    logic [6:0]  ev;
    logic        osc_ready;
    logic        synth_ready;
    logic        rx_mode;
    logic        osc_enable;
    logic        synth_enable;
    logic [5:0]  rx_status;
    logic [7:0]  q;
    logic [31:0] r;
    int          n_fail;
    int          check_count;
    int          cycles;
    localparam logic [7:0] A = radio_rx_pkg::RX_CTRL_ADDR;
    // ev: 0 data in, 1 buffer read, 2 packet start, 3 complete, 4 error, 5 done, 6 clear
    localparam logic [4:0] LVL [6] = '{5'h00, 5'h00, 5'h00, 5'h01, 5'h08, 5'h10};
    localparam logic [6:0] EVM [6] = '{7'h10, 7'h08, 7'h02, 7'h00, 7'h00, 7'h00};

    radio_reg_if rif ();
    radio_rx_host radio_rx_host_i (.pclk(pclk), .presetn(presetn), .bus(rif), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(hirq));
    radio_rx_ctrl radio_rx_ctrl_i (.pclk(pclk), .presetn(presetn), .bus(rif), .rx_level(rx_level),
        .rx_data_in(ev[0]), .rx_buffer_read(ev[1]), .sop_in(ev[2]), .rx_complete_in(ev[3]),
        .rx_error_in(ev[4]), .rx_done(ev[5]), .status_clear(ev[6]), .osc_ready(osc_ready),
        .synth_ready(synth_ready), .rx_mode(rx_mode), .osc_enable(osc_enable),
        .synth_enable(synth_enable), .rx_status(rx_status));
    radio_reg_monitor radio_reg_monitor_i (.pclk(pclk), .presetn(presetn), .req(rif.req), .we(rif.we),
        .addr(rif.addr), .wdata(rif.wdata), .rdata(rif.rdata), .ack(rif.ack), .irq(rif.irq));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic summarize();
        if (n_fail == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] o);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        o = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // one device access: command word, wait for the port ack, then poll until idle
    task automatic dev(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] o);
        logic [31:0] s;
        apb(1'b1, radio_rx_pkg::CMD_OFF, {1'b1, 14'h0000, wr, d, a}, s);
        @(posedge pclk iff (rif.ack === 1'b1));
        s = 32'h0000_0001;
        while (s[radio_rx_pkg::STAT_BUSY_BIT] !== 1'b0)
            apb(1'b0, radio_rx_pkg::STAT_OFF, 32'h0000_0000, s);
        o = s[15:8];
    endtask : dev

    task automatic pulse(input logic [6:0] m);
        @(posedge pclk);
        ev <= m;
        @(posedge pclk);
        ev <= 7'h00;
    endtask : pulse

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : wt

    // hang guard: far above the few hundred cycles the sequence needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            n_fail++;
            summarize();
        end
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        rx_level = 5'h00;
        ev = 7'h00;
        osc_ready = 1'b0;
        synth_ready = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        wt(1);
        chk(rx_status, 6'h00);
        dev(1'b0, A, 8'h00, q);
        chk(q, 8'h07);
        dev(1'b1, A, 8'h80, q);
        wt(3);
        chk({osc_enable, synth_enable, rx_mode}, 3'b110);
        @(posedge pclk);
        osc_ready <= 1'b1;
        synth_ready <= 1'b1;
        wt(4);
        chk(rx_mode, 1'b1);
        dev(1'b1, A, 8'h07, q);
        dev(1'b0, A, 8'h00, q);
        chk(q, 8'h87);
        pulse(7'h20);
        wt(2);
        chk({osc_enable, synth_enable, rx_mode}, 3'b000);
        dev(1'b0, A, 8'h00, q);
        chk(q, 8'h07);
        dev(1'b1, 8'h10, 8'hFF, q);
        dev(1'b0, 8'h10, 8'h00, q);
        chk(q, 8'h00);
        for (int i = 5; i >= 0; i--) begin
            dev(1'b1, A, 8'h01 << i, q);
            @(posedge pclk);
            rx_level <= LVL[i];
            pulse(EVM[i]);
            wt(3);
            chk(rx_status[i], 1'b1);
            chk(rif.irq, 1'b1);
            dev(1'b1, A, 8'h00, q);
            wt(3);
            chk(rif.irq, 1'b0);
            chk(rx_status[i], 1'b1);
        end
        @(posedge pclk);
        rx_level <= 5'h07;
        wt(3);
        chk(rx_status, 6'b001111);
        pulse(7'h40);
        wt(3);
        chk(rx_status, 6'b001100);
        dev(1'b1, A, 8'h80, q);
        pulse(7'h04);
        wt(3);
        chk(rx_status[2], 1'b0);
        @(posedge pclk);
        rx_level <= 5'h10;
        pulse(7'h01);
        wt(3);
        chk(rx_status[2], 1'b1);
        pulse(7'h20);
        apb(1'b1, radio_rx_pkg::IMASK_OFF, 32'h0000_0003, r);
        apb(1'b1, radio_rx_pkg::ISTAT_OFF, 32'h0000_0003, r);
        apb(1'b0, radio_rx_pkg::ISTAT_OFF, 32'h0000_0000, r);
        chk(r, 32'h0000_0000);
        dev(1'b0, A, 8'h00, q);
        wt(2);
        chk(hirq, 1'b1);
        apb(1'b1, radio_rx_pkg::IMASK_OFF, 32'h0000_0000, r);
        wt(2);
        chk(hirq, 1'b0);
        dev(1'b1, A, 8'h04, q);
        wt(3);
        apb(1'b0, radio_rx_pkg::ISTAT_OFF, 32'h0000_0000, r);
        chk(r, 32'h0000_0003);
        apb(1'b0, 12'h010, 32'h0000_0000, r);
        chk(r, 32'h0000_0000);
        chk(pslverr, 1'b0);
        summarize();
    end
endmodule : radio_receive_control_test
